/* pdl_pkg.sv */
// What this block does
// - Gate held low for normal propagation
// - Both gate pins always equal
// - Hold code stable while delay wanted
// - Wait code rise times step before an ungated code change
// - Gated flush: gate high, input low
// - Recommended width 100, period 200 percent
// - Suggested width 20, period 40 percent
// - Absolute width 10, period 20 percent
package pdl_pkg;

   // Device delay model, picoseconds.
   localparam int STEP_PS           = 1000;
   localparam int BASE_LATENCY_PS   = 9000;
   localparam int CLK_PERIOD_PS     = 5000;
   localparam int CODE_W            = 4;
   localparam int CODE_STEPS        = 15;
   localparam int CNT_W             = 16;
   // Limits on the pulse source, percent of full span latency.
   localparam int WIDTH_REC_PCT     = 100;
   localparam int PERIOD_REC_PCT    = 200;
   localparam int WIDTH_SUG_PCT     = 20;
   localparam int PERIOD_SUG_PCT    = 40;
   localparam int WIDTH_ABS_PCT     = 10;
   localparam int PERIOD_ABS_PCT    = 20;
   // Limit classes.
   localparam logic [1:0] CLASS_REC = 2'h0;
   localparam logic [1:0] CLASS_SUG = 2'h1;
   localparam logic [1:0] CLASS_ABS = 2'h2;

   // Pins driven toward the delay line.
   typedef struct packed {
      logic [CODE_W-1:0] step_select_code;
      logic              gate_a_b;
      logic              gate_b_b;
      logic              line_in;
   } pdl_pins_t;

   // Request from the user side.
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic              gate;
      logic              pulse;
      logic [CNT_W-1:0]  width_cyc;
      logic [CNT_W-1:0]  period_cyc;
   } pdl_req_t;

endpackage

/* pdl_wait_cnt.sv */
`timescale 1ns/100ps
// Loadable down counter; done is high once the count reaches zero.
module pdl_wait_cnt
   import pdl_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         ce_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] value_in,
   output logic              done_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // Next count: load wins, otherwise step down to zero.
   always_comb begin
      cnt_d = cnt_q;
      if (load_in) begin
         cnt_d = value_in;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cnt_q <= '0;
      end else if (ce_in) begin
         cnt_q <= cnt_d;
      end
   end

   assign done_out = (cnt_q == '0);
endmodule

/* pdl_host.sv */
`timescale 1ns/100ps
// Drives a programmable delay line: code, paired gate pins and the pulse input.
module pdl_host
   import pdl_pkg::*;
#(
   parameter int STEP_PICO = STEP_PS,
   parameter int BASE_PICO = BASE_LATENCY_PS
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             ce_in,
   input  wire logic             req_valid_in,
   input  wire pdl_req_t         req_in,
   output logic                  req_ready_out,
   output logic                  req_error_out,
   output logic [1:0]            limit_class_out,
   input  wire logic             true_out_in,
   input  wire logic             comp_out_in,
   output pdl_pins_t             pins_out,
   output logic                  busy_out
);
   // Cycles per step, rounded up so that every settling wait is long enough.
   localparam int STEP_CYC = (STEP_PICO + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Full span latency in cycles, rounded up.
   localparam int SPAN_CYC = (CODE_STEPS * STEP_PICO + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int W_REC = (SPAN_CYC * WIDTH_REC_PCT + 99) / 100;
   localparam int P_REC = (SPAN_CYC * PERIOD_REC_PCT + 99) / 100;
   localparam int W_SUG = (SPAN_CYC * WIDTH_SUG_PCT + 99) / 100;
   localparam int P_SUG = (SPAN_CYC * PERIOD_SUG_PCT + 99) / 100;
   localparam int W_ABS = (SPAN_CYC * WIDTH_ABS_PCT + 99) / 100;
   localparam int P_ABS = (SPAN_CYC * PERIOD_ABS_PCT + 99) / 100;
   // Latency of the longest code plus base, the time the last edge needs to emerge.
   localparam int OUT_CYC = (BASE_PICO + CODE_STEPS * STEP_PICO + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum {
      PDL_IDLE,
      PDL_HIGH,
      PDL_LOW,
      PDL_DRAIN,
      PDL_SETTLE,
      PDL_FLUSH
   } pdl_state_t;

   pdl_state_t        st_q;
   pdl_state_t        st_d;
   pdl_pins_t         pins_q;
   pdl_pins_t         pins_d;
   pdl_req_t          cur_q;
   pdl_req_t          cur_d;
   logic [1:0]        class_q;
   logic [1:0]        class_d;
   logic              err_q;
   logic              err_d;
   logic              gated_q;
   logic              gated_d;
   logic              load;
   logic [CNT_W-1:0]  load_val;
   logic              wait_done;
   logic [CNT_W-1:0]  w_cyc;
   logic [CNT_W-1:0]  p_cyc;
   // Last sampled device outputs, kept to see edges still leaving the line.
   logic              true_prev_q;
   logic              true_prev_d;
   logic              comp_prev_q;
   logic              comp_prev_d;
   logic              out_edge;
   logic [CNT_W-1:0]  rise_cyc;

   pdl_wait_cnt #(
      .W (CNT_W)
   ) u_wait (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .ce_in    (ce_in),
      .load_in  (load),
      .value_in (load_val),
      .done_out (wait_done)
   );

   assign w_cyc = req_in.width_cyc;
   assign p_cyc = req_in.period_cyc;

   // Any move on either device output means an edge is still emerging from the line.
   assign out_edge = (true_out_in != true_prev_q) || (comp_out_in != comp_prev_q);

   // Wait owed to a code rise; a falling code owes nothing beyond the line latency.
   // Restarting from this after a late output edge keeps the old code until the line is quiet.
   assign rise_cyc = (cur_q.code > pins_q.step_select_code) ?
                     CNT_W'(32'(cur_q.code - pins_q.step_select_code) * STEP_CYC) :
                     '0;

   // Ready only when idle; a new request may also change the code.
   assign req_ready_out   = (st_q == PDL_IDLE);
   assign busy_out        = (st_q != PDL_IDLE);
   assign req_error_out   = err_q;
   assign limit_class_out = class_q;
   assign pins_out        = pins_q;

   // Sequencer next-state and pin values.
   always_comb begin
      st_d     = st_q;
      pins_d   = pins_q;
      cur_d    = cur_q;
      class_d  = class_q;
      err_d    = err_q;
      gated_d  = gated_q;
      load     = 1'b0;
      load_val = '0;
      // Output history simply follows the sampled device outputs.
      true_prev_d = true_out_in;
      comp_prev_d = comp_out_in;
      case (st_q)
         PDL_IDLE: begin
            if (req_valid_in) begin
               cur_d = req_in;
               err_d = 1'b0;
               if (req_in.gate) begin
                  pins_d.line_in  = 1'b0;
                  pins_d.gate_a_b = 1'b1;
                  pins_d.gate_b_b = 1'b1;
                  gated_d  = 1'b1;
                  load     = 1'b1;
                  load_val = CNT_W'(32'(pins_q.step_select_code) * STEP_CYC + 1);
                  st_d     = PDL_FLUSH;
               end else if (req_in.code != pins_q.step_select_code) begin
                  load     = 1'b1;
                  load_val = (req_in.code > pins_q.step_select_code) ?
                             CNT_W'(32'(req_in.code - pins_q.step_select_code) * STEP_CYC + OUT_CYC) :
                             CNT_W'(OUT_CYC);
                  st_d     = PDL_SETTLE;
               end else if (req_in.pulse) begin
                  if (w_cyc < CNT_W'(W_ABS) || p_cyc < CNT_W'(P_ABS) || p_cyc <= w_cyc) begin
                     err_d = 1'b1;
                  end else begin
                     if (w_cyc >= CNT_W'(W_REC) && p_cyc >= CNT_W'(P_REC)) begin
                        class_d = CLASS_REC;
                     end else if (w_cyc >= CNT_W'(W_SUG) && p_cyc >= CNT_W'(P_SUG)) begin
                        class_d = CLASS_SUG;
                     end else begin
                        class_d = CLASS_ABS;
                     end
                     pins_d.gate_a_b = 1'b0;
                     pins_d.gate_b_b = 1'b0;
                     gated_d        = 1'b0;
                     pins_d.line_in = 1'b1;
                     load     = 1'b1;
                     load_val = w_cyc - CNT_W'(1);
                     st_d     = PDL_HIGH;
                  end
               end else begin
                  // A bare ungate request reopens the outputs after a flush.
                  pins_d.gate_a_b = 1'b0;
                  pins_d.gate_b_b = 1'b0;
                  gated_d         = 1'b0;
               end
            end
         end
         PDL_HIGH: begin
            // Fixed width and period keep any off-limit delay error constant.
            if (wait_done) begin
               pins_d.line_in = 1'b0;
               load     = 1'b1;
               load_val = cur_q.period_cyc - cur_q.width_cyc - CNT_W'(1);
               st_d     = PDL_LOW;
            end
         end
         PDL_LOW: begin
            if (wait_done) begin
               st_d = PDL_IDLE;
            end
         end
         PDL_SETTLE: begin
            if (out_edge) begin
               load     = 1'b1;
               load_val = rise_cyc + CNT_W'(1);
            end else if (wait_done) begin
               pins_d.step_select_code = cur_q.code;
               st_d = PDL_IDLE;
            end
         end
         PDL_FLUSH: begin
            if (wait_done) begin
               pins_d.step_select_code = cur_q.code;
               st_d = PDL_IDLE;
            end
         end
         default: begin
            st_d = PDL_IDLE;
         end
      endcase
   end

   // Sequencer registers; code reset to zero, gates high so the line starts quiet.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         st_q    <= PDL_IDLE;
         pins_q  <= '{step_select_code: '0, gate_a_b: 1'b1, gate_b_b: 1'b1, line_in: 1'b0};
         cur_q   <= '0;
         class_q <= CLASS_REC;
         err_q   <= 1'b0;
         gated_q <= 1'b1;
         // Gated outputs rest with the true side low and the inverted side high.
         true_prev_q <= 1'b0;
         comp_prev_q <= 1'b1;
      end else if (ce_in) begin
         st_q    <= st_d;
         pins_q  <= pins_d;
         cur_q   <= cur_d;
         class_q <= class_d;
         err_q   <= err_d;
         gated_q <= gated_d;
         true_prev_q <= true_prev_d;
         comp_prev_q <= comp_prev_d;
      end
   end
endmodule

/* pdl_host_props.sv */
`timescale 1ns/100ps
// Port relations of the host; reset masks all of them.
module pdl_host_props
   import pdl_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       ce_in,
   input wire logic       req_valid_in,
   input wire pdl_req_t   req_in,
   input wire logic       req_ready_out,
   input wire logic       req_error_out,
   input wire logic [1:0] limit_class_out,
   input wire logic       true_out_in,
   input wire logic       comp_out_in,
   input wire pdl_pins_t  pins_out,
   input wire logic       busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   gate_pair_a: assert property (pins_out.gate_a_b == pins_out.gate_b_b)
      else $error("gate pins differ");
   ready_idle_a: assert property (req_ready_out |-> !busy_out && !pins_out.line_in)
      else $error("idle with busy or input high");
   take_busy_a: assert property (ce_in && req_valid_in && req_ready_out |=> busy_out || req_error_out
                                 || !pins_out.gate_a_b)
      else $error("request taken without effect");
   code_hold_a: assert property (!$stable(pins_out.step_select_code) |-> $past(busy_out))
      else $error("code moved without a wait");
   flush_low_a: assert property (pins_out.gate_a_b |-> !pins_out.line_in)
      else $error("input high while gated");
   pulse_open_a: assert property ($rose(pins_out.line_in) |-> !pins_out.gate_a_b && busy_out)
      else $error("pulse sent while gated");
   refuse_quiet_a: assert property ($rose(req_error_out) |-> $stable(pins_out) && req_ready_out)
      else $error("refused pulse moved pins");
   class_legal_a: assert property (limit_class_out != 2'h3)
      else $error("unknown limit class");
   reset_gated_a: assert property ($rose(rst_b_in) |-> pins_out.gate_a_b && !pins_out.line_in)
      else $error("outputs not gated after reset");
   cover property ($rose(req_error_out));
   cover property ($rose(pins_out.gate_a_b));
   cover property ($fell(pins_out.line_in));
endmodule

bind pdl_host pdl_host_props u_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
   .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out), .req_error_out(req_error_out),
   .limit_class_out(limit_class_out), .true_out_in(true_out_in), .comp_out_in(comp_out_in),
   .pins_out(pins_out), .busy_out(busy_out));

/* pdl_dev.sv */
`timescale 1ns/100ps
// Behavioural delay line; transport delay keeps every edge, as the real line does.
module pdl_dev
   import pdl_pkg::*;
#(
   parameter int STEP_PICO = STEP_PS,
   parameter int BASE_PICO = BASE_LATENCY_PS
) (
   input  wire pdl_pins_t pins_in,
   output logic           true_out,
   output logic           comp_out
);
   logic dly = 1'b0;
   always @(pins_in.line_in) dly <= #((BASE_PICO + STEP_PICO * pins_in.step_select_code) / 1000.0) pins_in.line_in;
   // true and inverted outputs, forced while gated.
   assign true_out = (pins_in.gate_a_b | pins_in.gate_b_b) ? 1'b0 : dly;
   assign comp_out = (pins_in.gate_a_b | pins_in.gate_b_b) ? 1'b1 : ~dly;
endmodule

/* programmable_delay_line_tb.sv */
`timescale 1ns/100ps
// Drives the host and times edges through the device model.
module programmable_delay_line_tb;
   import pdl_pkg::*;
   logic       clk = 0, rst_b = 0, ce = 1, vld = 0, rdy, err, busy, t_o, c_o;
   logic [1:0] cls;
   pdl_req_t   req = '0;
   pdl_pins_t  pins;
   int         n_errors = 0, num_checks = 0, prev = 0, d, nb;
   realtime    t0;
   pdl_host u_dut (.clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .req_valid_in(vld), .req_in(req),
      .req_ready_out(rdy), .req_error_out(err), .limit_class_out(cls), .true_out_in(t_o),
      .comp_out_in(c_o), .pins_out(pins), .busy_out(busy));
   pdl_dev u_dev (.pins_in(pins), .true_out(t_o), .comp_out(c_o));
   // Inputs move on the falling edge, away from the sampling edge.
   initial forever #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One request, held until taken, then waits for idle under a bound.
   task automatic send(input logic [3:0] c, input logic g, p, input int w, pr);
      @(negedge clk);
      req = '{c, g, p, 16'(w), 16'(pr)};
      vld = 1;
      // Hold the request until an edge at which the host is ready.
      while (!rdy) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      vld = 0;
      nb = 0;
      while (!rdy && nb < 300) begin
         @(negedge clk);
         nb++;
      end
      if (!rdy) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, rdy, 1'b1);
      end
   endtask
   // Code change, then a pulse whose edge is timed at the device output.
   task automatic pulse_dly(input logic [3:0] c);
      send(c, 0, 0, 0, 0);
      fork
         send(c, 0, 1, 20, 40);
         begin
            @(posedge pins.line_in);
            t0 = $realtime;
            @(posedge t_o);
            d = int'(($realtime - t0) * 10);
            // Both outputs follow the same delayed value; let the inverted one settle first.
            #1;
            chk(c_o, 0);
         end
      join
      chk(d, (BASE_LATENCY_PS + STEP_PS * c) / 100);
      chk(d >= prev, 1);
      prev = d;
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog sized well above the expected run of a few microseconds.
   initial begin
      #60us;
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk) rst_b = 1;
      chk({pins, t_o, c_o}, 9'h019);
      // Clock enable low: a request must leave every pin where reset put it.
      ce = 0;
      send(4'h5, 0, 1, 3, 6);
      chk({pins, busy}, 8'h0c);
      ce = 1;
      for (int c = 0; c < 16; c++) pulse_dly(4'(c));
      prev = 0;
      pulse_dly(4'h2);
      // A code rise must wait out the step difference and the line latency.
      send(4'h6, 0, 0, 0, 0);
      chk(nb >= ((6 - 2) * STEP_PS + BASE_LATENCY_PS + CODE_STEPS * STEP_PS) / CLK_PERIOD_PS, 1);
      send(4'h6, 0, 1, 5, 5);
      chk({err, rdy, busy}, 3'h6);
      send(4'h6, 0, 1, 1, 2);
      chk({err, cls}, {1'b0, CLASS_SUG});
      send(4'h6, 0, 1, 3, 6);
      chk({err, cls}, {1'b0, CLASS_REC});
      send(4'h9, 1, 0, 0, 0);
      chk({pins, t_o, c_o}, 9'h139);
      prev = 0;
      pulse_dly(4'h9);
      pulse_dly(4'h9);
      print_verdict;
   end
endmodule
